// ===== rtl/ppc_defs.svh
/*
 * Constants of the port pin configuration block: register indices,
 * reset values, bus field positions and pin positions.
 * Assumes inclusion by bare name from the package and the module.
 */
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// register indices; byte address is four times the index
`define PPC_IDX_W 10
`define PPC_IDX_DATA 10'h258
`define PPC_IDX_INPUT 10'h259
`define PPC_IDX_DIR 10'h25A
`define PPC_IDX_DRIVE 10'h25B
`define PPC_IDX_PULL 10'h25C
`define PPC_IDX_POL 10'h25D
`define PPC_IDX_MASK 10'h25E
`define PPC_IDX_FLAG 10'h25F
// word index sits above the two byte-lane bits
`define PPC_IDX_LSB 2
`define PPC_IDX_MSB 11

// reset values
`define PPC_RST_DIR 8'h00
`define PPC_RST_DRIVE 8'h00
`define PPC_RST_PULL 8'h00
`define PPC_RST_POL 8'h00
`define PPC_RST_DATA 8'h00
`define PPC_RST_MASK 8'h00
`define PPC_RST_FLAG 8'h00

// bus encodings
`define PPC_HTRANS_ACTIVE 1
`define PPC_HRESP_OKAY 1'h0
`define PPC_PORT_W 8

// pins with special overrides
`define PPC_PIN_SHDN 7
`define PPC_PIN_SCI_TX 2
`define PPC_PIN_TIM_MID 1
`define PPC_PIN_SCI_RX 0

`endif

// ===== rtl/ppc_pkg.sv
/*
 * Types of the port pin configuration block.
 * Assumes the constant header is on the include path.
 */
`include "ppc_defs.svh"

package ppc_pkg;
    // bus slave sequencing
    typedef enum logic [1:0] {
        PPC_IDLE,
        PPC_RD_WAIT,
        PPC_RD_DONE
    } ppc_state_e;

    typedef logic [`PPC_IDX_W-1:0] ppc_idx_t;
endpackage

// ===== rtl/ppc_port.sv
/*
 * Eight-pin general purpose port configuration: direction with
 * peripheral overrides, reduced drive, pull device control, edge flags
 * with interrupt, all behind an AHB-Lite slave.
 * Assumes a single AHB-Lite master and pins that arrive asynchronously.
 */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "ppc_defs.svh"

module ppc_port
    import ppc_pkg::*;
#(
    parameter int NPINS = `PPC_PORT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] drive_reduced,
    output logic [NPINS-1:0] pull_en,
    output logic [NPINS-1:0] pull_down,
    output logic [NPINS-1:0] port_p_direction,
    output logic [NPINS-1:0] port_p_polarity_select,
    output logic irq,
    input wire logic [NPINS-1:0] pwm_chan_en,
    input wire logic pwm_shutdown_en,
    input wire logic [2:0] timer_oc_en,
    input wire logic serial_en,
    input wire logic [1:0] serial_pin_dir
);

    // the override map is wired to fixed pin positions
    if (NPINS != `PPC_PORT_W) begin : g_bad_width
        $error("ppc_port supports exactly eight pins");
    end

    ppc_state_e state_q;
    ppc_idx_t idx_q;
    logic wr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [NPINS-1:0] dir_q, drive_q, pull_q, pol_q, data_q, mask_q, flag_q;
    logic [NPINS-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_prev_q;
    logic [NPINS-1:0] dir_eff_d, dir_eff_q;
    logic [NPINS-1:0] drive_out_q, pull_en_q, pull_down_q;
    logic irq_q;
    logic [NPINS-1:0] wdat;
    logic [NPINS-1:0] set_v;
    logic [NPINS-1:0] rd_val;
    logic addr_take;
    logic wr_dir, wr_drive, wr_pull, wr_pol, wr_data, wr_mask, wr_flag;

    // an active transfer is taken only when the bus is ready
    assign addr_take = hsel && hready && htrans[`PPC_HTRANS_ACTIVE];
    assign wdat = hwdata[NPINS-1:0];

    // write strobes live in the data phase that follows the address phase
    always_comb begin
        wr_dir = 1'b0;
        wr_drive = 1'b0;
        wr_pull = 1'b0;
        wr_pol = 1'b0;
        wr_data = 1'b0;
        wr_mask = 1'b0;
        wr_flag = 1'b0;
        if (wr_q && idx_q == `PPC_IDX_DIR) begin
            wr_dir = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_DRIVE) begin
            wr_drive = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_PULL) begin
            wr_pull = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_POL) begin
            wr_pol = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_DATA) begin
            wr_data = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_MASK) begin
            wr_mask = 1'b1;
        end else if (wr_q && idx_q == `PPC_IDX_FLAG) begin
            wr_flag = 1'b1;
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rd_val = '0;
        if (idx_q == `PPC_IDX_DATA) begin
            rd_val = (dir_q & data_q) | (~dir_q & filt_q);
        end else if (idx_q == `PPC_IDX_INPUT) begin
            rd_val = filt_q;
        end else if (idx_q == `PPC_IDX_DIR) begin
            rd_val = dir_q;
        end else if (idx_q == `PPC_IDX_DRIVE) begin
            rd_val = drive_q;
        end else if (idx_q == `PPC_IDX_PULL) begin
            rd_val = pull_q;
        end else if (idx_q == `PPC_IDX_POL) begin
            rd_val = pol_q;
        end else if (idx_q == `PPC_IDX_MASK) begin
            rd_val = mask_q;
        end else if (idx_q == `PPC_IDX_FLAG) begin
            rd_val = flag_q;
        end
    end

    // bus sequencing: writes take no wait, reads take one so that a read
    // right behind a write sees the freshly written value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= PPC_IDLE;
            idx_q <= '0;
            wr_q <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            case (state_q)
                PPC_IDLE: begin
                    wr_q <= addr_take && hwrite;
                    if (addr_take) begin
                        idx_q <= haddr[`PPC_IDX_MSB:`PPC_IDX_LSB];
                    end
                    if (addr_take && !hwrite) begin
                        hreadyout_q <= 1'b0;
                        state_q <= PPC_RD_WAIT;
                    end
                end
                PPC_RD_WAIT: begin
                    wr_q <= 1'b0;
                    hrdata_q <= {{(32 - NPINS){1'b0}}, rd_val};
                    hreadyout_q <= 1'b1;
                    state_q <= PPC_RD_DONE;
                end
                default: begin
                    // data is sampled now; a new address phase may sit here
                    wr_q <= addr_take && hwrite;
                    if (addr_take) begin
                        idx_q <= haddr[`PPC_IDX_MSB:`PPC_IDX_LSB];
                    end
                    if (addr_take && !hwrite) begin
                        hreadyout_q <= 1'b0;
                        state_q <= PPC_RD_WAIT;
                    end else begin
                        state_q <= PPC_IDLE;
                    end
                end
            endcase
        end
    end

    // configuration registers, writable in any mode; overrides act only downstream,
    // so software reads back the value it wrote, save DATA bits set as inputs, which read the filtered pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_q <= `PPC_RST_DIR;
            drive_q <= `PPC_RST_DRIVE;
            pull_q <= `PPC_RST_PULL;
            pol_q <= `PPC_RST_POL;
            data_q <= `PPC_RST_DATA;
            mask_q <= `PPC_RST_MASK;
        end else begin
            if (wr_dir) dir_q <= wdat;
            if (wr_drive) drive_q <= wdat;
            if (wr_pull) pull_q <= wdat;
            if (wr_pol) pol_q <= wdat;
            if (wr_data) data_q <= wdat;
            if (wr_mask) mask_q <= wdat;
        end
    end

    // pin synchroniser; the filtered level moves only when stages 2 and 3 agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
            filt_prev_q <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
            filt_prev_q <= filt_q;
        end
    end

    // effective direction per pin, priority shutdown (pin 7 only), pwm, timer, serial, register
    for (genvar i = 0; i < NPINS; i++) begin : g_dir
        always_comb begin
            dir_eff_d[i] = dir_q[i];
            if (i == `PPC_PIN_SHDN && pwm_shutdown_en) begin
                dir_eff_d[i] = 1'b0;
            end else if (pwm_chan_en[i]) begin
                dir_eff_d[i] = 1'b1;
            end else if (i <= `PPC_PIN_SCI_TX && timer_oc_en[i % (`PPC_PIN_SCI_TX + 1)]) begin
                dir_eff_d[i] = 1'b1;
            end else if (i == `PPC_PIN_SCI_TX && serial_en) begin
                dir_eff_d[i] = serial_pin_dir[1];
            end else if (i == `PPC_PIN_SCI_RX && serial_en) begin
                dir_eff_d[i] = serial_pin_dir[0];
            end
        end
    end

    // pin controls; the pad sees reduced drive only when driving out and
    // the pull device only when receiving, whatever function owns the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_eff_q <= '0;
            drive_out_q <= '0;
            pull_en_q <= '0;
            pull_down_q <= '0;
        end else begin
            dir_eff_q <= dir_eff_d;
            drive_out_q <= drive_q & dir_eff_d;
            pull_en_q <= pull_q & ~dir_eff_d;
            pull_down_q <= pol_q;
        end
    end

    // active edge follows polarity: rising when 1, falling when 0
    assign set_v = (pol_q & filt_q & ~filt_prev_q)
        | (~pol_q & ~filt_q & filt_prev_q);

    // sticky edge flags; a new edge beats a simultaneous clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= `PPC_RST_FLAG;
        end else begin
            flag_q <= (flag_q & ~(wr_flag ? wdat : '0)) | set_v;
        end
    end

    // level interrupt while any unmasked flag stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & mask_q);
        end
    end

    // every output below is a flop or a constant tie
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = `PPC_HRESP_OKAY;
    assign pin_o = data_q;
    assign pin_oe = dir_eff_q;
    assign drive_reduced = drive_out_q;
    assign pull_en = pull_en_q;
    assign pull_down = pull_down_q;
    assign port_p_direction = dir_q;
    assign port_p_polarity_select = pol_q;
    assign irq = irq_q;

    // property checks, all of them idle while reset is held
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // true when no peripheral claims any pin, so the stored bits alone decide
    logic no_ovr;
    assign no_ovr = !(|pwm_chan_en) && !pwm_shutdown_en && !(|timer_oc_en) && !serial_en;

    // a read costs exactly one wait state
    sequence rd_taken;
        state_q != PPC_RD_WAIT && addr_take && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    plain_dir_a: assert property (no_ovr |=> pin_oe == $past(dir_q))
        else $error("direction does not follow register");
    pwm_force_a: assert property (pwm_chan_en[3] |=> pin_oe[3])
        else $error("pwm channel did not force output");
    // pin 7: the channel forces output unless shutdown holds it as input
    pwm_pin7_a: assert property (pwm_chan_en[7] && !pwm_shutdown_en |=> pin_oe[7])
        else $error("pwm channel did not force pin 7");
    shutdown_in_a: assert property (pwm_shutdown_en |=> !pin_oe[7])
        else $error("shutdown did not force input");
    dir_kept_a: assert property ((|pwm_chan_en) && !wr_dir |=> $stable(dir_q))
        else $error("override changed stored direction");
    timer_force_a: assert property (!pwm_chan_en[1] && timer_oc_en[1] |=> pin_oe[1])
        else $error("timer compare did not force output");
    serial_dir_a: assert property (!pwm_chan_en[0] && !timer_oc_en[0] && serial_en |=>
        pin_oe[0] == $past(serial_pin_dir[0]))
        else $error("serial direction not applied");
    drive_input_a: assert property ((drive_reduced & ~pin_oe) == '0)
        else $error("reduced drive on input pin");
    pull_output_a: assert property ((pull_en & pin_oe) == '0)
        else $error("pull device on output pin");
    flag_set_a: assert property ((|set_v) |=> (flag_q & $past(set_v)) == $past(set_v))
        else $error("active edge lost");
    read_wait_a: assert property (rd_taken |=> rd_answer)
        else $error("read answer timing wrong");

    // shared pins 2 and 0 follow pwm, then timer, then serial
    timer_pin0_a: assert property (!pwm_chan_en[0] && timer_oc_en[0] |=> pin_oe[0])
        else $error("timer compare did not force pin 0");
    serial_tx_a: assert property (!pwm_chan_en[2] && !timer_oc_en[2] && serial_en |=>
        pin_oe[2] == $past(serial_pin_dir[1]))
        else $error("serial direction not applied on pin 2");

    // writes never wait; a stalled write would shift every later data phase
    write_ready_a: assert property (addr_take && hwrite |=> hreadyout)
        else $error("write answer was delayed");

    // edge flags: the polarity bit picks the edge, a written one clears
    rise_flag_a: assert property (pol_q[0] && $rose(filt_q[0]) |=> flag_q[0])
        else $error("rising edge did not set flag");
    fall_flag_a: assert property (!pol_q[0] && $fell(filt_q[0]) |=> flag_q[0])
        else $error("falling edge did not set flag");
    flag_clear_a: assert property (wr_flag |=> (flag_q & $past(wdat & ~set_v)) == '0)
        else $error("written one did not clear flag");

endmodule

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the port pin configuration block: bus tasks,
 * random configuration against peripheral overrides, data reads, edge flags.
 * Assumes the package and constant header on the include path; bench is sole master.
 */
`timescale 1ns/1ps
`include "ppc_defs.svh"

module tb_top import ppc_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, pwm_shutdown_en, serial_en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, serial_pin_dir, sd;
    logic [2:0] hsize, timer_oc_en, tm;
    logic [7:0] pin_i, pin_o, pin_oe, drive_reduced, pull_en, pull_down, pwm_chan_en;
    logic [7:0] port_p_direction, port_p_polarity_select, d, dv, pl, po, p, r, m, pw, e;
    logic sh, se;
    int errors, n_checks;

    ppc_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .drive_reduced(drive_reduced),
        .pull_en(pull_en), .pull_down(pull_down), .port_p_direction(port_p_direction),
        .port_p_polarity_select(port_p_polarity_select), .irq(irq),
        .pwm_chan_en(pwm_chan_en), .pwm_shutdown_en(pwm_shutdown_en),
        .timer_oc_en(timer_oc_en), .serial_en(serial_en), .serial_pin_dir(serial_pin_dir));

    // free-running bus clock, 8 ns
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    function automatic logic [7:0] rnd8();
        return 8'($urandom);
    endfunction

    // effective direction: pwm beats timer beats serial beats the stored bit
    function automatic logic [7:0] exp_oe(logic [7:0] dir, logic [7:0] pwm, logic shd,
        logic [2:0] tim, logic ser, logic [1:0] sdir);
        logic [7:0] o;
        o = dir;
        if (ser) begin
            o[2] = sdir[1];
            o[0] = sdir[0];
        end
        o[2:0] = o[2:0] | tim;
        o = o | pwm;
        if (shd) o[7] = 1'b0;
        return o;
    endfunction

    // single word transfer; holds each phase until hready is sampled high
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h00000, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic chk_reg(input logic [9:0] idx, input logic [7:0] x);
        xfer(1'b0, idx, 8'h00);
        n_checks++;
        if (rd !== {24'h000000, x}) begin
            errors++;
            $display("mismatch t=%0t idx %h got %h exp %h", $time, idx, rd, x);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] x);
        n_checks++;
        if (got !== x) begin
            errors++;
            $display("mismatch t=%0t pins got %h exp %h", $time, got, x);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // cut a hang short well beyond the expected run length
    initial begin
        #(8 * 40000);
        errors++;
        give_verdict();
    end

    initial begin
        errors = 0;
        n_checks = 0;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        pin_i = 8'h00;
        {pwm_chan_en, pwm_shutdown_en, timer_oc_en, serial_en, serial_pin_dir} = '0;
        r = 8'($urandom(15100));
        wt(6);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_reg(`PPC_IDX_DIR, `PPC_RST_DIR);
        chk_reg(`PPC_IDX_DRIVE, `PPC_RST_DRIVE);
        chk_pin(pin_oe, 8'h00);
        chk_pin({7'h00, hresp}, 8'h00);
        // unmapped place swallows writes and reads as zero
        xfer(1'b1, 10'h000, 8'hFF);
        chk_reg(10'h000, 8'h00);
        // random configuration against overrides; first pass has all overrides on
        for (int k = 0; k < 24; k++) begin
            dv = rnd8(); d = rnd8(); pl = rnd8(); po = rnd8();
            pw = (k == 0) ? 8'hFF : rnd8() & rnd8() & rnd8();
            sh = (k == 0) | 1'($urandom);
            tm = (k == 0) ? 3'h7 : 3'($urandom) & 3'($urandom);
            se = (k == 0) | 1'($urandom);
            sd = 2'($urandom);
            xfer(1'b1, `PPC_IDX_DIR, dv);
            xfer(1'b1, `PPC_IDX_DRIVE, d);
            xfer(1'b1, `PPC_IDX_PULL, pl);
            xfer(1'b1, `PPC_IDX_POL, po);
            pwm_chan_en <= pw; pwm_shutdown_en <= sh; timer_oc_en <= tm;
            serial_en <= se; serial_pin_dir <= sd;
            wt(3);
            e = exp_oe(dv, pw, sh, tm, se, sd);
            chk_pin(pin_oe, e);
            chk_pin(drive_reduced, d & e);
            chk_pin(pull_en, pl & ~e);
            chk_pin(pull_down, po);
            chk_pin(port_p_polarity_select, po);
            chk_pin(port_p_direction, dv);
            chk_reg(`PPC_IDX_DIR, dv);
            chk_reg(`PPC_IDX_DRIVE, d);
            chk_reg(`PPC_IDX_PULL, pl);
            chk_reg(`PPC_IDX_POL, po);
        end
        {pwm_chan_en, pwm_shutdown_en, timer_oc_en, serial_en} <= '0;
        // data reads: stored bit on outputs, filtered pin on inputs
        for (int k = 0; k < 6; k++) begin
            d = rnd8(); dv = rnd8(); p = rnd8();
            pin_i <= p;
            xfer(1'b1, `PPC_IDX_DIR, dv);
            xfer(1'b1, `PPC_IDX_DATA, d);
            wt(8);
            chk_pin(pin_o, d);
            chk_reg(`PPC_IDX_DATA, (d & dv) | (p & ~dv));
            chk_reg(`PPC_IDX_INPUT, p);
        end
        // edge flags against polarity, masked onto irq; first pass fully masked
        for (int k = 0; k < 8; k++) begin
            po = rnd8();
            m = (k == 0) ? 8'h00 : rnd8();
            r = rnd8();
            xfer(1'b1, `PPC_IDX_POL, po);
            xfer(1'b1, `PPC_IDX_MASK, m);
            xfer(1'b1, `PPC_IDX_FLAG, 8'hFF);
            wt(2);
            chk_pin({7'h00, irq}, 8'h00);
            pin_i <= r;
            wt(10);
            e = (~p & r & po) | (p & ~r & ~po);
            chk_reg(`PPC_IDX_FLAG, e);
            chk_pin({7'h00, irq}, {7'h00, |(e & m)});
            p = r;
        end
        xfer(1'b1, `PPC_IDX_FLAG, 8'hFF);
        wt(2);
        chk_reg(`PPC_IDX_FLAG, 8'h00);
        chk_pin({7'h00, irq}, 8'h00);
        give_verdict();
    end
endmodule
